//--- pei_evt_grp.sv
// One eight-flag sticky event group with clear-on-read
`timescale 1ns/1ps
`default_nettype none
module pei_evt_grp (
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst,
	input  wire logic [7:0] i_set,
	input  wire logic       i_clr,
	output logic      [7:0] o_flags
);
	import pei_pkg::*;

	pei_grp_t st;
	pei_grp_t next_st;

	// Set beats clear so an event in the read cycle survives
	always_comb begin
		next_st = st;
		next_st.flags = (st.flags & ~{8{i_clr}}) | i_set;
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			st.flags <= PEI_RST_EVENT;
		end else begin
			st <= next_st;
		end
	end

	assign o_flags = st.flags;

	// ************************************************************
	// Checks
	// ************************************************************
	set_wins_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(|i_set) |=> ((o_flags & $past(i_set)) == $past(i_set)))
		else $error("event set lost");
	clr_empty_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(i_clr && i_set == 8'h00) |=> (o_flags == 8'h00))
		else $error("group not cleared after read");
endmodule // pei_evt_grp
`default_nettype wire

//--- pei_host.sv
// Serial-bus host model that drives the register bank from the far side
`timescale 1ns/1ps
`default_nettype none
// ********************************************************************
// Host controller model
// ********************************************************************
module pei_host (
	input  wire logic i_sys_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_rel
);
	// Bus idles released high; the pull-up wins while nobody pulls
	initial begin
		o_scl     = 1'b1;
		o_sda_rel = 1'b1;
	end

	// Wait n clocks, then step just past the edge
	task automatic tick(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask

	// Start, also used as repeated start
	task automatic start();
		o_sda_rel = 1'b1;
		tick(5);
		o_scl = 1'b1;
		tick(5);
		o_sda_rel = 1'b0;
		tick(5);
		o_scl = 1'b0;
		tick(5);
	endtask

	// Stop ends the transfer and lets the interrupt pin move
	task automatic stop();
		o_sda_rel = 1'b0;
		tick(5);
		o_scl = 1'b1;
		tick(5);
		o_sda_rel = 1'b1;
		tick(5);
	endtask

	// One bit; data moves only while the clock is low, phases above 4 clocks
	task automatic bit1(input logic b, output logic s);
		o_sda_rel = b;
		tick(5);
		o_scl = 1'b1;
		tick(3);
		s = i_sda;
		tick(2);
		o_scl = 1'b0;
		tick(2);
	endtask

	// Byte plus acknowledge; callers never trust set-only readback
	task automatic xbyte(input logic [7:0] d, input logic nack,
		output logic [7:0] q, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit1(d[i], s);
			q[i] = s;
		end
		bit1(nack, s);
		ack = ~s;
	endtask
endmodule // pei_host
`default_nettype wire

//--- pei_pkg.sv
// Constants and types of the event and interrupt register bank
// Summary of operation
// - Hardware mode: a Class 4 port gets the higher Type 2 current unaided.
// - Clear-on-read views return contents, then zero; writes to them ignored.
// - Read/write registers take writes; reads return the value unchanged.
// - Read-only registers read without side effect; writes change nothing.
// - Set-only registers take writes; their read data is meaningless.
// - Summary at 00h: supply..port event flags, bits 7..0, reset 80h.
// - Mask at 01h, same layout; resets 80h in mode 0, E4h in mode 1.
// - Port events: power good 7..4, status change 3..0; views 02h/03h.
// - Detection events: class done 7..4, signature done 3..0; 04h/05h.
// - Fault events: disconnect 7..4, cutoff timeout 3..0; 06h/07h.
// - Supply view 0Ah: over-temp bit 7, rail undervoltages bits 5, 4; 32h.
// - Interrupt output changes only while the serial bus is idle.
package pei_pkg;
	localparam logic [7:0] PEI_OFS_SUMMARY  = 8'h00;
	localparam logic [7:0] PEI_OFS_MASK     = 8'h01;
	localparam logic [7:0] PEI_OFS_PORT     = 8'h02;
	localparam logic [7:0] PEI_OFS_PORT_COR = 8'h03;
	localparam logic [7:0] PEI_OFS_DET      = 8'h04;
	localparam logic [7:0] PEI_OFS_DET_COR  = 8'h05;
	localparam logic [7:0] PEI_OFS_FLT      = 8'h06;
	localparam logic [7:0] PEI_OFS_FLT_COR  = 8'h07;
	localparam logic [7:0] PEI_OFS_TIM      = 8'h08;
	localparam logic [7:0] PEI_OFS_TIM_COR  = 8'h09;
	localparam logic [7:0] PEI_OFS_SUPPLY   = 8'h0a;
	localparam logic [7:0] PEI_RST_SUMMARY  = 8'h80;
	localparam logic [7:0] PEI_RST_MASK_SW  = 8'h80;
	localparam logic [7:0] PEI_RST_MASK_HW  = 8'he4;
	localparam logic [7:0] PEI_RST_EVENT    = 8'h00;
	localparam logic [7:0] PEI_RST_SUPPLY   = 8'h32;
	localparam logic [7:0] PEI_SUP_FIXED    = 8'h02;
	localparam int         PEI_SUP_TEMP     = 7;
	localparam int         PEI_SUP_LOW      = 5;
	localparam int         PEI_SUP_MAIN     = 4;
	localparam logic [2:0] PEI_DEV_PREFIX   = 3'h2;
	localparam logic [1:0] PEI_MODE_SETTLE  = 2'h3;
	localparam logic [3:0] PEI_BITS_BYTE    = 4'h8;
	// Groups: 0 port, 1 detection, 2 fault, 3 timing
	localparam int         PEI_GRP_N        = 4;

	typedef enum logic [7:0] {
		PEI_IDLE  = 8'h01,
		PEI_ADDR  = 8'h02,
		PEI_ACK_A = 8'h04,
		PEI_WRITE = 8'h08,
		PEI_ACK_W = 8'h10,
		PEI_READ  = 8'h20,
		PEI_ACK_R = 8'h40,
		PEI_HOLD  = 8'h80
	} pei_fsm_t;

	// Per-port event pulses from the port machinery
	typedef struct packed {
		logic [3:0] pgd;
		logic [3:0] psc;
		logic [3:0] class_done;
		logic [3:0] sig_done;
		logic [3:0] dis;
		logic [3:0] cutoff_timeout;
		logic [3:0] limit_timeout;
		logic [3:0] startup_timeout;
	} pei_evt_t;

	typedef struct packed {
		logic over_temp;
		logic low_rail_undervoltage;
		logic main_rail_undervoltage;
	} pei_supply_t;

	typedef struct packed {
		logic [7:0] flags;
	} pei_grp_t;

	typedef struct packed {
		logic       scl_s1, scl_s2, scl_s3;
		logic       sda_s1, sda_s2, sda_s3;
		logic       mode_s1, mode_s2;
		logic [3:0] adr_s1, adr_s2;
		logic [1:0] settle;
		logic       mode_done;
		pei_fsm_t   fsm;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic [7:0] ptr;
		logic       rw;
		logic       first;
		logic       nacked;
		logic       sda_lvl;
		logic       sda_oe_n;
		logic       int_n;
		logic [7:0] mask;
		logic [7:0] supply;
		logic [3:0] type2;
	} pei_st_t;
endpackage

//--- pei_regs.sv
// Serial-bus event and interrupt register bank, top level
`timescale 1ns/1ps
`default_nettype none
module pei_regs (
	input  wire logic                 i_sys_clk,
	input  wire logic                 i_rst,
	input  wire logic                 i_scl,
	input  wire logic                 i_sda,
	output logic                      o_sda,
	output logic                      o_sda_oe_n,
	input  wire logic [3:0]           i_dev_addr,
	input  wire logic                 i_mode,
	input  wire pei_pkg::pei_evt_t    i_evt,
	input  wire pei_pkg::pei_supply_t i_supply,
	input  wire logic [3:0]           i_class4_seen,
	output logic                      o_int_n,
	output logic [3:0]                o_type2_grant
);
	import pei_pkg::*;

	pei_st_t              st;
	pei_st_t              next_st;
	logic [PEI_GRP_N-1:0] grp_clr;
	logic [7:0]           grp_set [PEI_GRP_N];
	logic [7:0]           grp_flags [PEI_GRP_N];
	logic [7:0]           summary;
	logic [7:0]           rdata;
	logic                 scl_rise;
	logic                 scl_fall;
	logic                 bus_start;
	logic                 bus_stop;
	logic                 load_rd;
	logic                 mode_hw;

	// ************************************************************
	// Event groups
	// ************************************************************
	assign grp_set[0] = {i_evt.pgd, i_evt.psc};
	assign grp_set[1] = {i_evt.class_done, i_evt.sig_done};
	assign grp_set[2] = {i_evt.dis, i_evt.cutoff_timeout};
	assign grp_set[3] = {i_evt.limit_timeout, i_evt.startup_timeout};

	for (genvar g = 0; g < PEI_GRP_N; g++) begin : g_grp
		pei_evt_grp u_grp (
			.i_sys_clk (i_sys_clk),
			.i_rst     (i_rst),
			.i_set     (grp_set[g]),
			.i_clr     (grp_clr[g]),
			.o_flags   (grp_flags[g])
		);
	end

	// Summary bits 6..0 follow their groups, bit 7 the supply view; nothing is latched here
	always_comb begin
		summary[7] = |(st.supply & ~PEI_SUP_FIXED);
		summary[6] = |grp_flags[3][3:0];
		summary[5] = |grp_flags[2][3:0];
		summary[4] = |grp_flags[1][7:4];
		summary[3] = |grp_flags[1][3:0];
		summary[2] = |grp_flags[2][7:4];
		summary[1] = |grp_flags[0][7:4];
		summary[0] = |grp_flags[0][3:0];
	end

	// ************************************************************
	// Register read decode
	// ************************************************************
	// Both views of a group read the same flags; offsets past 0Ah read zero
	always_comb begin
		if (st.ptr == PEI_OFS_SUMMARY) begin
			rdata = summary;
		end else if (st.ptr == PEI_OFS_MASK) begin
			rdata = st.mask;
		end else if (st.ptr == PEI_OFS_PORT || st.ptr == PEI_OFS_PORT_COR) begin
			rdata = grp_flags[0];
		end else if (st.ptr == PEI_OFS_DET || st.ptr == PEI_OFS_DET_COR) begin
			rdata = grp_flags[1];
		end else if (st.ptr == PEI_OFS_FLT || st.ptr == PEI_OFS_FLT_COR) begin
			rdata = grp_flags[2];
		end else if (st.ptr == PEI_OFS_TIM || st.ptr == PEI_OFS_TIM_COR) begin
			rdata = grp_flags[3];
		end else if (st.ptr == PEI_OFS_SUPPLY) begin
			rdata = st.supply;
		end else begin
			rdata = 8'h00;
		end
	end

	// Bus edges from the synchronised copies only
	assign scl_rise  = st.scl_s2 & ~st.scl_s3;
	assign scl_fall  = ~st.scl_s2 & st.scl_s3;
	assign bus_start = st.scl_s2 & st.scl_s3 & st.sda_s3 & ~st.sda_s2;
	assign bus_stop  = st.scl_s2 & st.scl_s3 & ~st.sda_s3 & st.sda_s2;
	assign mode_hw   = st.mode_done & st.mode_s2;

	// A byte is fetched for the host after the address ack or a master ack
	assign load_rd = scl_fall & ((st.fsm == PEI_ACK_A && st.rw) ||
		(st.fsm == PEI_ACK_R && !st.nacked));

	// Clear is combinational so it lands on the same edge as the snapshot
	always_comb begin
		grp_clr[0] = load_rd && st.ptr == PEI_OFS_PORT_COR;
		grp_clr[1] = load_rd && st.ptr == PEI_OFS_DET_COR;
		grp_clr[2] = load_rd && st.ptr == PEI_OFS_FLT_COR;
		grp_clr[3] = load_rd && st.ptr == PEI_OFS_TIM_COR;
	end

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		next_st = st;
		next_st.scl_s1 = i_scl;
		next_st.scl_s2 = st.scl_s1;
		next_st.scl_s3 = st.scl_s2;
		next_st.sda_s1 = i_sda;
		next_st.sda_s2 = st.sda_s1;
		next_st.sda_s3 = st.sda_s2;
		next_st.mode_s1 = i_mode;
		next_st.mode_s2 = st.mode_s1;
		next_st.adr_s1 = i_dev_addr;
		next_st.adr_s2 = st.adr_s1;
		next_st.sda_lvl = 1'b0;
		// Mode pin settles through the synchroniser before the mask follows it
		if (!st.mode_done) begin
			if (st.settle == PEI_MODE_SETTLE) begin
				next_st.mode_done = 1'b1;
				if (st.mode_s2) begin
					next_st.mask = PEI_RST_MASK_HW;
				end
			end else begin
				next_st.settle = st.settle + 2'h1;
			end
		end
		// Serial slave; a start anywhere restarts, a stop always frees the bus
		if (bus_start) begin
			next_st.fsm = PEI_ADDR;
			next_st.cnt = 4'h0;
			next_st.sda_oe_n = 1'b1;
		end else if (bus_stop) begin
			next_st.fsm = PEI_IDLE;
			next_st.sda_oe_n = 1'b1;
		end else begin
			case (st.fsm)
				PEI_ADDR, PEI_WRITE: begin
					if (scl_rise) begin
						next_st.shift = {st.shift[6:0], st.sda_s2};
						next_st.cnt = st.cnt + 4'h1;
					end else if (scl_fall && st.cnt == PEI_BITS_BYTE) begin
						next_st.cnt = 4'h0;
						if (st.fsm == PEI_ADDR) begin
							if (st.shift[7:1] == {PEI_DEV_PREFIX, st.adr_s2}) begin
								next_st.rw = st.shift[0];
								next_st.fsm = PEI_ACK_A;
								next_st.sda_oe_n = 1'b0;
							end else begin
								next_st.fsm = PEI_HOLD;
							end
						end else begin
							next_st.fsm = PEI_ACK_W;
							next_st.sda_oe_n = 1'b0;
							next_st.first = 1'b0;
							if (st.first) begin
								next_st.ptr = st.shift;
							end else begin
								// Only the mask stores; other offsets drop the data
								if (st.ptr == PEI_OFS_MASK) begin
									next_st.mask = st.shift;
								end
								next_st.ptr = st.ptr + 8'h01;
							end
						end
					end
				end
				PEI_ACK_A: begin
					if (scl_fall && !st.rw) begin
						next_st.fsm = PEI_WRITE;
						next_st.sda_oe_n = 1'b1;
						next_st.first = 1'b1;
					end
				end
				PEI_ACK_W: begin
					if (scl_fall) begin
						next_st.fsm = PEI_WRITE;
						next_st.sda_oe_n = 1'b1;
					end
				end
				PEI_READ: begin
					if (scl_rise) begin
						next_st.cnt = st.cnt + 4'h1;
					end else if (scl_fall) begin
						if (st.cnt == PEI_BITS_BYTE) begin
							next_st.fsm = PEI_ACK_R;
							next_st.sda_oe_n = 1'b1;
							next_st.cnt = 4'h0;
						end else begin
							next_st.shift = {st.shift[6:0], 1'b0};
							next_st.sda_oe_n = st.shift[6];
						end
					end
				end
				PEI_ACK_R: begin
					if (scl_rise) begin
						next_st.nacked = st.sda_s2;
					end else if (scl_fall && st.nacked) begin
						next_st.fsm = PEI_HOLD;
					end
				end
				PEI_HOLD: begin
					next_st.sda_oe_n = 1'b1;
				end
				default: begin
					next_st.fsm = PEI_IDLE;
					next_st.sda_oe_n = 1'b1;
				end
			endcase
			// Snapshot read byte and advance; a clear-on-read view clears its group on this edge
			if (load_rd) begin
				next_st.shift = rdata;
				next_st.sda_oe_n = rdata[7];
				next_st.ptr = st.ptr + 8'h01;
				next_st.fsm = PEI_READ;
				next_st.cnt = 4'h0;
				next_st.nacked = 1'b0;
			end
		end
		// Live supply levels; bit 1 always reads one
		next_st.supply = PEI_SUP_FIXED;
		next_st.supply[PEI_SUP_TEMP] = i_supply.over_temp;
		next_st.supply[PEI_SUP_LOW] = i_supply.low_rail_undervoltage;
		next_st.supply[PEI_SUP_MAIN] = i_supply.main_rail_undervoltage;
		// Interrupt frozen during a transfer so the host sees a stable line
		if (st.fsm == PEI_IDLE) begin
			next_st.int_n = ~|(summary & ~st.mask);
		end
		// Grant stays until the port disconnects; set wins
		next_st.type2 = (st.type2 & ~i_evt.dis) | (i_class4_seen & {4{mode_hw}});
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			st <= '0;
			st.scl_s1 <= 1'b1;
			st.scl_s2 <= 1'b1;
			st.scl_s3 <= 1'b1;
			st.sda_s1 <= 1'b1;
			st.sda_s2 <= 1'b1;
			st.sda_s3 <= 1'b1;
			st.fsm <= PEI_IDLE;
			st.sda_oe_n <= 1'b1;
			st.int_n <= 1'b1;
			st.mask <= PEI_RST_MASK_SW;
			st.supply <= PEI_RST_SUPPLY;
		end else begin
			st <= next_st;
		end
	end

	// Every output straight from the state register
	assign o_sda         = st.sda_lvl;
	assign o_sda_oe_n    = st.sda_oe_n;
	assign o_int_n       = st.int_n;
	assign o_type2_grant = st.type2;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	logic wr_byte;
	assign wr_byte = st.fsm == PEI_WRITE && scl_fall && st.cnt == PEI_BITS_BYTE && !st.first;

	mask_write_a: assert property (wr_byte && st.ptr == PEI_OFS_MASK
		|=> st.mask == $past(st.shift)) else $error("mask write not stored");
	ro_write_a: assert property (wr_byte && st.ptr != PEI_OFS_MASK
		|=> $stable(st.mask) && st.ptr == $past(st.ptr) + 8'h01) else $error("write leaked");
	int_hold_a: assert property (st.fsm != PEI_IDLE |=> $stable(o_int_n))
		else $error("interrupt moved mid transfer");
	int_level_a: assert property (st.fsm == PEI_IDLE
		|=> o_int_n == !(|$past(summary & ~st.mask))) else $error("interrupt level wrong");
	mask_mode_a: assert property ($rose(st.mode_done)
		|-> st.mask == ($past(st.mode_s2) ? PEI_RST_MASK_HW : PEI_RST_MASK_SW))
		else $error("mask mode default wrong");
	type2_a: assert property (mode_hw && |i_class4_seen
		|=> (o_type2_grant & $past(i_class4_seen)) == $past(i_class4_seen))
		else $error("type 2 grant missing");
	cor_read_a: assert property (load_rd && st.ptr == PEI_OFS_FLT_COR
		|=> st.shift == $past(grp_flags[2]) && st.fsm == PEI_READ)
		else $error("clearing read snapshot wrong");
	view_read_a: assert property (load_rd && st.ptr == PEI_OFS_DET
		|=> grp_flags[1] == ($past(grp_flags[1]) | $past(grp_set[1])))
		else $error("view read disturbed flags");
	supply_a: assert property (1'b1
		|=> st.supply[PEI_SUP_TEMP] == $past(i_supply.over_temp)
		&& st.supply[1]) else $error("supply view wrong");

	cor_cov_c: cover property (load_rd && st.ptr == PEI_OFS_PORT_COR ##1 grp_flags[0] == 8'h00);
	mask_cov_c: cover property (wr_byte && st.ptr == PEI_OFS_MASK);
	int_cov_c: cover property ($fell(o_int_n));
	grant_cov_c: cover property ($rose(o_type2_grant[3]));
endmodule // pei_regs
`default_nettype wire

//--- pei_regs_tb.sv
// Self-checking bench for the event and interrupt register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
// ********************************************************************
// Bench top
// ********************************************************************
module pei_regs_tb;
	import pei_pkg::*;
	localparam logic [7:0] DEV_W = 8'h4a; // Strap 5 under prefix 010
	logic          clk = 1'b0;
	logic          rst = 1'b1;
	logic          mode;
	logic          scl;
	logic          sda_rel;
	logic          o_sda;
	logic          oe_n;
	logic          int_n;
	logic [3:0]    t2;
	logic [3:0]    c4;
	pei_evt_t      evt;
	pei_evt_t      ev;
	pei_supply_t   sup;
	logic [7:0]    q;
	logic          a;
	logic [7:0]    rb [11];
	int            n_fail = 0;
	int            check_count = 0;
	int            cyc = 0;
	logic [7:0] rst_exp [11] = '{8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h32};
	logic [7:0] exp1 [7] = '{8'h10, 8'h02, 8'h02, 8'h40, 8'h40, 8'h80, 8'h80};
	logic [7:0] exp2 [7] = '{8'h08, 8'h10, 8'h10, 8'h02, 8'h02, 8'h04, 8'h04};
	wire  logic    sda_w;

	// Open-drain data wire with pull-up
	assign sda_w = oe_n ? sda_rel : o_sda;

	pei_host u_pei_host (
		.i_sys_clk (clk),
		.i_sda     (sda_w),
		.o_scl     (scl),
		.o_sda_rel (sda_rel)
	);

	pei_regs u_pei_regs (
		.i_sys_clk     (clk),
		.i_rst         (rst),
		.i_scl         (scl),
		.i_sda         (sda_w),
		.o_sda         (o_sda),
		.o_sda_oe_n    (oe_n),
		.i_dev_addr    (4'h5),
		.i_mode        (mode),
		.i_evt         (evt),
		.i_supply      (sup),
		.i_class4_seen (c4),
		.o_int_n       (int_n),
		.o_type2_grant (t2)
	);

	// Clock and hang guard; a run of this size needs about 13k cycles
	initial begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			final_report();
		end
	end

	task automatic final_report();
		if (n_fail == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Reset held 6 cycles, then room for the mode pin to settle
	task automatic rst_dut();
		rst = 1'b1;
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b0;
		repeat (10) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		u_pei_host.start();
		u_pei_host.xbyte(DEV_W, 1'b1, q, a);
		u_pei_host.xbyte(p, 1'b1, q, a);
		u_pei_host.xbyte(d, 1'b1, q, a);
		`CHK(a, 1'b1)
		u_pei_host.stop();
	endtask

	// Pointer write, repeated start, n bytes with NACK on the last
	task automatic rd(input logic [7:0] p, input int n);
		u_pei_host.start();
		u_pei_host.xbyte(DEV_W, 1'b1, q, a);
		u_pei_host.xbyte(p, 1'b1, q, a);
		u_pei_host.start();
		u_pei_host.xbyte(DEV_W | 8'h01, 1'b1, q, a);
		for (int i = 0; i < n; i++)
			u_pei_host.xbyte(8'hff, i == n - 1, rb[i], a);
		u_pei_host.stop();
	endtask

	task automatic rchk(input logic [7:0] p, input logic [7:0] e);
		rd(p, 1);
		`CHK(rb[0], e)
	endtask

	task automatic pulse(input pei_evt_t e);
		@(posedge clk);
		#1;
		evt = e;
		@(posedge clk);
		#1;
		evt = '0;
	endtask

	task automatic c4p(input logic [3:0] v);
		@(posedge clk);
		#1;
		c4 = v;
		@(posedge clk);
		#1;
		c4 = 4'h0;
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic waitint(input logic v);
		for (int i = 0; i < 40 && int_n !== v; i++) @(posedge clk);
		#1;
	endtask

	// Main sequence
	initial begin
		mode = 1'b0;
		evt  = '0;
		sup  = 3'h3;
		c4   = 4'h0;
		rst_dut();
		rd(8'h00, 11);
		for (int i = 0; i < 11; i++) `CHK(rb[i], rst_exp[i])
		wr(8'h01, 8'h5a);
		rchk(8'h01, 8'h5a);
		rchk(8'h01, 8'h5a);
		// A foreign address is left unanswered and changes nothing
		u_pei_host.start();
		u_pei_host.xbyte(DEV_W ^ 8'h02, 1'b1, q, a);
		`CHK(a, 1'b0)
		u_pei_host.xbyte(8'h01, 1'b1, q, a);
		u_pei_host.xbyte(8'h00, 1'b1, q, a);
		u_pei_host.stop();
		rchk(8'h01, 8'h5a);
		wr(8'h00, 8'h00);
		rchk(8'h00, 8'h80);
		wr(8'h0a, 8'h00);
		rchk(8'h0a, 8'h32);
		// First batch of events, one per group half
		ev = '0;
		ev.pgd = 4'h1;
		ev.sig_done = 4'h2;
		ev.dis = 4'h4;
		ev.limit_timeout = 4'h8;
		pulse(ev);
		wr(8'h03, 8'h00);
		rchk(8'h02, 8'h10);
		rchk(8'h00, 8'h8e);
		rd(8'h03, 7);
		for (int i = 0; i < 7; i++) `CHK(rb[i], exp1[i])
		rchk(8'h00, 8'h80);
		// Second batch fills the other halves
		ev = '0;
		ev.psc = 4'h8;
		ev.class_done = 4'h1;
		ev.cutoff_timeout = 4'h2;
		ev.startup_timeout = 4'h4;
		pulse(ev);
		rchk(8'h00, 8'hf1);
		rd(8'h03, 7);
		for (int i = 0; i < 7; i++) `CHK(rb[i], exp2[i])
		sup = 3'h7;
		rchk(8'h0a, 8'hb2);
		sup = 3'h0;
		rchk(8'h0a, 8'h02);
		rchk(8'h00, 8'h00);
		// Interrupt must wait for the end of the transfer
		wr(8'h01, 8'hfd);
		u_pei_host.start();
		u_pei_host.xbyte(DEV_W, 1'b1, q, a);
		ev = '0;
		ev.pgd = 4'h2;
		pulse(ev);
		repeat (20) @(posedge clk);
		#1;
		`CHK(int_n, 1'b1)
		u_pei_host.xbyte(8'h02, 1'b1, q, a);
		u_pei_host.stop();
		waitint(1'b0);
		`CHK(int_n, 1'b0)
		rd(8'h03, 1);
		waitint(1'b1);
		`CHK(int_n, 1'b1)
		c4p(4'h1);
		`CHK(t2, 4'h0)
		// Hardware mode
		mode = 1'b1;
		rst_dut();
		rchk(8'h01, 8'he4);
		c4p(4'hc);
		`CHK(t2, 4'hc)
		ev = '0;
		ev.dis = 4'h4;
		pulse(ev);
		repeat (3) @(posedge clk);
		#1;
		`CHK(t2, 4'h8)
		final_report();
	end
endmodule // pei_regs_tb
`default_nettype wire
